// >>> verilog/drv_status_pkg.sv
package drv_status_pkg;
  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_MOVE_MIN = 4'h1;
  localparam logic [3:0] ADDR_INPOS = 4'h2;
  localparam logic [3:0] ADDR_SPEED = 4'h3;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_NOTICE = 4'h5;
  // ----------------------------------------
  // Control fields and reset values
  // ----------------------------------------
  localparam int CTRL_AUTO_CLR_BIT = 0;
  localparam int CTRL_LED_EN_BIT = 1;
  localparam int CTRL_CUTBACK_EN_BIT = 2;
  localparam int CTRL_VA_MODE_LSB = 3;
  localparam int CTRL_PULSE_MODE_BIT = 5;
  localparam int CTRL_SVE_LSB = 8;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0007;
  localparam logic [7:0] MOVE_MIN_RESET = 8'h00;
  localparam logic [7:0] INPOS_RANGE_RESET = 8'h12;
  localparam logic [7:0] INPOS_RANGE_MAX = 8'hB4;
  localparam logic [7:0] INPOS_OFFSET_RESET = 8'h00;
  localparam logic [7:0] SPEED_RANGE_RESET = 8'h1E;
  localparam logic [7:0] SVE_FULL = 8'h64;
  localparam logic [15:0] DEVIATION_LIMIT = 16'h0012;
  // ----------------------------------------
  // Speed-attain modes
  // ----------------------------------------
  localparam logic [1:0] VA_FEEDBACK = 2'h0;
  localparam logic [1:0] VA_COMMAND = 2'h1;
  localparam logic [1:0] VA_BOTH = 2'h2;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_HZ = 25_000_000;
  localparam int MS_NUM = 1;
  localparam int MS_DEN = 1000;
  localparam int CYCLES_PER_MS = CLK_HZ * MS_NUM / MS_DEN;
  localparam int BLINK_MS = 250;
  localparam int STARTUP_US = 100;
  localparam int STARTUP_CYCLES = CLK_HZ / 1_000_000 * STARTUP_US;
  localparam int NOTICE_W = 8;
endpackage : drv_status_pkg

// >>> verilog/ms_timer.sv
`timescale 1ns/100ps
module ms_timer
  import drv_status_pkg::*;
#(
  parameter int CYCLES = CYCLES_PER_MS
) (
  input wire logic i_clk,
  input wire logic i_rst,
  output logic o_tick
);
  // Free-running tick once per millisecond; shared by hold and blink timers.
  logic [$clog2(CYCLES)-1:0] cnt_q;
  always_ff @(posedge i_clk) begin
    if (i_rst || cnt_q == ($clog2(CYCLES))'(CYCLES - 1)) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_tick <= 1'b0;
    end else begin
      o_tick <= (cnt_q == ($clog2(CYCLES))'(CYCLES - 1));
    end
  end
endmodule : ms_timer

// >>> verilog/driver_status_output_logic.sv
// Our own choices: strobed register access and the register addresses.
`timescale 1ns/100ps
// What this block does
// - Control-select input picks alpha or servo emulation
// - Alarm drives open on, closed off, red blinking
// - Excitation-off alarm de-excites after motor stops
// - System ready asserts after startup completes
// - Notice output with optional automatic clearing
// - Notice blinks red and green together
// - Maintenance busy follows maintenance command
// - Each notice category has own output
// - Excitation output follows motor excitation
// - Main supply output follows main power
// - Brake output high means brake released
// - Regen output when resistor fitted and regenerating
// - Ready only when all start conditions hold
// - Moving output with minimum on time
// - Oscillation busy during internal oscillation
// - In-position within window around offset target
// - No in-position while interrupted
// - Cutback output only when cutback enabled
// - Torque limit on overtorque or push limit
// - Alpha mode limit: deviation over limit
// - Servo emulation limit depends on ratio
// - Speed attained by selected criterion
// - Clear input releases notice when manual
// - Speed mode codes; pulse mode feedback only
module driver_status_output_logic
  import drv_status_pkg::*;
#(
  parameter int STARTUP = STARTUP_CYCLES,
  parameter int TICK_CYCLES = CYCLES_PER_MS
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [3:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  input wire logic i_current_ctrl_select,
  input wire logic i_alarm,
  input wire logic i_alarm_deexcite,
  input wire logic i_control_supply_on,
  input wire logic i_main_supply,
  input wire logic i_start_any,
  input wire logic i_free,
  input wire logic i_con_assigned,
  input wire logic i_con,
  input wire logic i_stop_any,
  input wire logic i_stop_deenergize_input,
  input wire logic i_deviation_clear_input,
  input wire logic i_tool_busy,
  input wire logic i_maint_cmd,
  input wire logic [NOTICE_W-1:0] i_notice_cause,
  input wire logic i_notice_clear_input,
  input wire logic i_excite_req,
  input wire logic i_brake_release,
  input wire logic i_regen_fitted,
  input wire logic i_regen_level,
  input wire logic i_motor_running,
  input wire logic i_oscillating,
  input wire logic i_position_done,
  input wire logic i_interrupted,
  input wire logic signed [15:0] i_position_error,
  input wire logic i_cutback_reached,
  input wire logic i_overtorque,
  input wire logic i_push_limit,
  input wire logic [15:0] i_deviation,
  input wire logic i_current_at_limit,
  input wire logic [15:0] i_feedback_speed,
  input wire logic [15:0] i_command_speed,
  input wire logic [15:0] i_target_speed,
  output logic o_servo_emul_mode,
  output logic o_alarm_normally_open,
  output logic o_alarm_normally_closed,
  output logic o_led_red,
  output logic o_led_green,
  output logic o_motor_stop,
  output logic o_system_ready_flag,
  output logic o_notice,
  output logic [NOTICE_W-1:0] o_notice_flags,
  output logic o_maintenance_busy,
  output logic o_excitation_active,
  output logic o_main_supply_on,
  output logic o_brake_release_ctrl,
  output logic o_regen_active,
  output logic o_ready,
  output logic o_moving,
  output logic o_oscillation_busy,
  output logic o_in_position,
  output logic o_current_cutback_active,
  output logic o_torque_limit_hit,
  output logic o_speed_attained
);
  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  localparam int NSYNC = 27;
  logic [NSYNC-1:0] raw_in, s1_q, s2_q;
  assign raw_in = {i_current_ctrl_select, i_alarm, i_alarm_deexcite, i_control_supply_on,
                   i_main_supply, i_start_any, i_free, i_con_assigned, i_con, i_stop_any,
                   i_stop_deenergize_input, i_deviation_clear_input, i_tool_busy,
                   i_maint_cmd, i_notice_clear_input, i_excite_req, i_brake_release,
                   i_regen_fitted, i_regen_level, i_motor_running, i_oscillating,
                   i_position_done, i_interrupted, i_cutback_reached, i_overtorque,
                   i_push_limit, i_current_at_limit};
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      s1_q <= '0;
      s2_q <= '0;
    end else begin
      s1_q <= raw_in;
      s2_q <= s1_q;
    end
  end
  logic current_ctrl_select, alm, alm_off, ctl_pwr, main_pwr, start_in, free_in, con_asg, con_in;
  logic stop_in, stop_deenergize_input, dev_clr, tool, maint, nclr, exc, brk, rg_fit, rg_lvl;
  logic running, osc, pos_done, intr, cb, ovt, push, cur_lim;
  assign {current_ctrl_select, alm, alm_off, ctl_pwr, main_pwr, start_in, free_in, con_asg, con_in,
          stop_in, stop_deenergize_input, dev_clr, tool, maint, nclr, exc, brk, rg_fit, rg_lvl,
          running, osc, pos_done, intr, cb, ovt, push, cur_lim} = s2_q;
  // Multi-bit quantities are sampled twice; the source holds them stable for many cycles.
  logic [NOTICE_W-1:0] ncause1_q, ncause_q;
  logic signed [15:0] perr1_q, perr_q;
  logic [15:0] dev1_q, dev_q, fb1_q, fb_q, cmd1_q, cmd_q, tgt1_q, tgt_q;
  always_ff @(posedge i_clk) begin
    {ncause1_q, perr1_q, dev1_q, fb1_q, cmd1_q, tgt1_q} <= {i_notice_cause, i_position_error,
      i_deviation, i_feedback_speed, i_command_speed, i_target_speed};
    {ncause_q, perr_q, dev_q, fb_q, cmd_q, tgt_q} <= {ncause1_q, perr1_q, dev1_q, fb1_q,
      cmd1_q, tgt1_q};
  end
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [31:0] ctrl_q;
  logic [7:0] move_min_q, inpos_range_q, inpos_offset_q, speed_range_q, servo_emul_ratio;
  logic [NOTICE_W-1:0] notice_q;
  logic [1:0] va_mode;
  assign va_mode = ctrl_q[CTRL_VA_MODE_LSB +: 2];
  assign servo_emul_ratio = ctrl_q[CTRL_SVE_LSB +: 8];
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ctrl_q <= CTRL_RESET;
      move_min_q <= MOVE_MIN_RESET;
      inpos_range_q <= INPOS_RANGE_RESET;
      inpos_offset_q <= INPOS_OFFSET_RESET;
      speed_range_q <= SPEED_RANGE_RESET;
    end else if (i_wr) begin
      unique case (i_addr)
        ADDR_CTRL: ctrl_q <= i_wdata;
        ADDR_MOVE_MIN: move_min_q <= i_wdata[7:0];
        ADDR_INPOS: begin
          // Window above its maximum is clipped to keep the compare meaningful.
          inpos_range_q <= (i_wdata[7:0] > INPOS_RANGE_MAX) ? INPOS_RANGE_MAX : i_wdata[7:0];
          inpos_offset_q <= i_wdata[15:8];
        end
        ADDR_SPEED: speed_range_q <= i_wdata[7:0];
        default: ;
      endcase
    end
  end
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_rdata <= '0;
    end else if (i_rd) begin
      unique case (i_addr)
        ADDR_CTRL: o_rdata <= ctrl_q;
        ADDR_MOVE_MIN: o_rdata <= {24'h000000, move_min_q};
        ADDR_INPOS: o_rdata <= {16'h0000, inpos_offset_q, inpos_range_q};
        ADDR_SPEED: o_rdata <= {24'h000000, speed_range_q};
        ADDR_STATUS: o_rdata <= {17'h00000, o_speed_attained, o_torque_limit_hit,
                                 o_current_cutback_active, o_in_position, o_oscillation_busy,
                                 o_moving, o_ready, o_regen_active, o_brake_release_ctrl,
                                 o_main_supply_on, o_excitation_active, o_maintenance_busy,
                                 o_notice, o_system_ready_flag, o_alarm_normally_open};
        ADDR_NOTICE: o_rdata <= {{(32 - NOTICE_W){1'b0}}, notice_q};
        default: o_rdata <= '0;
      endcase
    end else begin
      o_rdata <= '0;
    end
  end
  // ----------------------------------------
  // Timers
  // ----------------------------------------
  logic ms_tick;
  ms_timer #(.CYCLES(TICK_CYCLES)) u_ms (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .o_tick(ms_tick)
  );
  logic [$clog2(STARTUP + 1)-1:0] boot_q;
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      boot_q <= '0;
    end else if (boot_q != ($clog2(STARTUP + 1))'(STARTUP)) begin
      boot_q <= boot_q + 1'b1;
    end
  end
  logic [7:0] blink_cnt_q;
  logic blink_q;
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      blink_cnt_q <= '0;
      blink_q <= 1'b0;
    end else if (ms_tick) begin
      if (blink_cnt_q == 8'(BLINK_MS - 1)) begin
        blink_cnt_q <= '0;
        blink_q <= ~blink_q;
      end else begin
        blink_cnt_q <= blink_cnt_q + 1'b1;
      end
    end
  end
  // ----------------------------------------
  // Notice flags
  // ----------------------------------------
  // Sticky notice flags
  // Manual release by clear
  // Set beats clear, so a cause still present keeps its flag.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      notice_q <= '0;
    end else begin
      notice_q <= ncause_q | ((ctrl_q[CTRL_AUTO_CLR_BIT] || nclr) ? '0 : notice_q);
    end
  end
  // ----------------------------------------
  // Status decisions
  // ----------------------------------------
  function automatic logic in_band(input logic [15:0] a, input logic [15:0] b,
                                   input logic [7:0] tol);
    logic [15:0] d;
    d = (a > b) ? a - b : b - a;
    return d <= {8'h00, tol};
  endfunction : in_band
  logic ready_c, tlc_c, va_c, inpos_c, settled, dev_over;
  logic signed [15:0] ofs_err;
  assign ready_c = ctl_pwr && main_pwr && !start_in && !free_in && (!con_asg || con_in)
                   && !stop_in && !stop_deenergize_input && !dev_clr && !alm && !running && !tool && !maint;
  assign dev_over = dev_q > DEVIATION_LIMIT;
  always_comb begin
    tlc_c = ovt || push;
    if (!current_ctrl_select || servo_emul_ratio == 8'h00) begin
      tlc_c = tlc_c || dev_over;
    end else if (servo_emul_ratio >= SVE_FULL) begin
      tlc_c = tlc_c || cur_lim;
    end else begin
      tlc_c = tlc_c || (dev_over && cur_lim);
    end
  end
  always_comb begin
    va_c = in_band(fb_q, cmd_q, speed_range_q);
    if (!ctrl_q[CTRL_PULSE_MODE_BIT]) begin
      unique case (va_mode)
        VA_COMMAND: va_c = cmd_q == tgt_q;
        VA_BOTH: va_c = in_band(fb_q, tgt_q, speed_range_q);
        default: va_c = in_band(fb_q, cmd_q, speed_range_q);
      endcase
    end
  end
  assign ofs_err = perr_q - 16'(signed'(inpos_offset_q));
  assign settled = (ofs_err < 0 ? -ofs_err : ofs_err) <= $signed({8'h00, inpos_range_q});
  assign inpos_c = pos_done && !intr && settled;
  // ----------------------------------------
  // Moving output with hold
  // ----------------------------------------
  logic [8:0] hold_q;
  // Minimum on time hold
  // The tick runs free, so one extra tick covers the millisecond already begun.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      hold_q <= '0;
    end else if (running && !o_moving) begin
      hold_q <= (move_min_q == 8'h00) ? 9'h000 : {1'b0, move_min_q} + 9'h001;
    end else if (ms_tick && hold_q != 9'h000) begin
      hold_q <= hold_q - 1'b1;
    end
  end
  // ----------------------------------------
  // Output registers
  // ----------------------------------------
  // Registered outputs
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      {o_servo_emul_mode, o_alarm_normally_open, o_alarm_normally_closed, o_led_red,
       o_led_green, o_motor_stop, o_system_ready_flag, o_notice, o_notice_flags,
       o_maintenance_busy, o_excitation_active, o_main_supply_on, o_brake_release_ctrl,
       o_regen_active, o_ready, o_moving, o_oscillation_busy, o_in_position,
       o_current_cutback_active, o_torque_limit_hit, o_speed_attained} <= '0;
    end else begin
      o_servo_emul_mode <= current_ctrl_select;
      o_alarm_normally_open <= alm;
      o_alarm_normally_closed <= !alm;
      o_motor_stop <= alm;
      o_led_red <= alm ? blink_q : (ctrl_q[CTRL_LED_EN_BIT] && |notice_q && blink_q);
      o_led_green <= alm ? 1'b0 : (ctrl_q[CTRL_LED_EN_BIT] && |notice_q ? blink_q : 1'b1);
      o_system_ready_flag <= boot_q == ($clog2(STARTUP + 1))'(STARTUP) && ctl_pwr;
      o_notice <= |notice_q;
      o_notice_flags <= notice_q;
      o_maintenance_busy <= maint;
      o_excitation_active <= exc && !(alm && alm_off && !running);
      o_main_supply_on <= main_pwr;
      o_brake_release_ctrl <= brk;
      o_regen_active <= rg_fit && rg_lvl;
      o_ready <= ready_c;
      o_moving <= running || (o_moving && hold_q != 9'h000);
      o_oscillation_busy <= osc;
      o_in_position <= inpos_c;
      o_current_cutback_active <= ctrl_q[CTRL_CUTBACK_EN_BIT] && cb;
      o_torque_limit_hit <= tlc_c;
      o_speed_attained <= va_c;
    end
  end
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_alarm_seen;
    alm;
  endsequence
  chk_alarm_pair: assert property (@(posedge i_clk) disable iff (i_rst)
    s_alarm_seen |=> o_alarm_normally_open && !o_alarm_normally_closed)
    else $error("alarm pair wrong");
  chk_mode_follow: assert property (@(posedge i_clk) disable iff (i_rst)
    $rose(current_ctrl_select) |=> o_servo_emul_mode) else $error("mode not followed");
  chk_ready_alarm: assert property (@(posedge i_clk) disable iff (i_rst)
    alm |=> !o_ready) else $error("ready during alarm");
  chk_move_hold: assert property (@(posedge i_clk) disable iff (i_rst)
    running |=> o_moving) else $error("moving lost");
  chk_cutback_off: assert property (@(posedge i_clk) disable iff (i_rst)
    !ctrl_q[CTRL_CUTBACK_EN_BIT] |=> !o_current_cutback_active)
    else $error("cutback while disabled");
  chk_inpos_intr: assert property (@(posedge i_clk) disable iff (i_rst)
    intr |=> !o_in_position) else $error("in-position after interrupt");
  chk_alpha_tlc: assert property (@(posedge i_clk) disable iff (i_rst)
    (!current_ctrl_select && dev_over) |=> o_torque_limit_hit) else $error("torque limit missed");
  chk_notice_hold: assert property (@(posedge i_clk) disable iff (i_rst)
    (!ctrl_q[CTRL_AUTO_CLR_BIT] && o_notice && !nclr && !i_wr)[*2] |=> o_notice)
    else $error("notice dropped without clear");
  chk_regen: assert property (@(posedge i_clk) disable iff (i_rst)
    !rg_fit |=> !o_regen_active) else $error("regen without resistor");
endmodule : driver_status_output_logic

// >>> testbench/ctrl_model.sv
`timescale 1ns/100ps
module ctrl_model (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_go,
  input wire logic i_ready,
  input wire logic i_brake_release_ctrl,
  output logic o_start_any,
  output logic o_brake_engaged
);
  // ----------------------------------------
  // Start command and brake handling
  // ----------------------------------------
  // Start only after ready.
  always_ff @(posedge i_clk) begin
    if (i_rst || !i_go) begin
      o_start_any <= 1'b0;
    end else if (i_ready) begin
      o_start_any <= 1'b1;
    end
  end
  // Brake follows release output.
  // The brake is held during reset, since a free load is the unsafe case.
  always_ff @(posedge i_clk) begin
    o_brake_engaged <= i_rst ? 1'b1 : !i_brake_release_ctrl;
  end
endmodule : ctrl_model

// >>> testbench/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  import drv_status_pkg::*;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [3:0] i_addr = 4'h0;
  logic [31:0] i_wdata = 32'h0;
  logic i_wr = 1'b0, i_rd = 1'b0;
  logic [31:0] o_rdata, d;
  logic [7:0] blk = 8'h00;
  logic i_current_ctrl_select = 0, i_alarm_deexcite = 0, i_control_supply_on = 1;
  logic i_main_supply = 1, i_con_assigned = 0, i_con = 0, i_notice_clear_input = 0;
  logic i_excite_req = 0, i_brake_release = 0, i_regen_fitted = 0, i_regen_level = 0;
  logic i_position_done = 0, i_interrupted = 0, i_cutback_reached = 0;
  logic i_overtorque = 0, i_push_limit = 0, i_current_at_limit = 0, i_oscillating = 0;
  logic i_alarm, i_maint_cmd, i_tool_busy, i_deviation_clear_input, i_motor_running;
  logic i_stop_deenergize_input, i_stop_any, i_free, i_start_any, go = 0, brake_held;
  logic [NOTICE_W-1:0] i_notice_cause = '0, o_notice_flags;
  logic signed [15:0] i_position_error = 16'sh0000;
  logic [15:0] i_deviation = 16'h0, i_feedback_speed = 16'h0;
  logic [15:0] i_command_speed = 16'h0, i_target_speed = 16'h0;
  logic o_servo_emul_mode, o_alarm_normally_open, o_alarm_normally_closed, o_led_red;
  logic o_led_green, o_motor_stop, o_system_ready_flag, o_notice, o_maintenance_busy;
  logic o_excitation_active, o_main_supply_on, o_brake_release_ctrl, o_regen_active;
  logic o_ready, o_moving, o_oscillation_busy, o_in_position, o_current_cutback_active;
  logic o_torque_limit_hit, o_speed_attained;
  int bad_count = 0, n_compared = 0;
  assign {i_motor_running, i_alarm, i_maint_cmd, i_tool_busy, i_deviation_clear_input,
    i_stop_deenergize_input, i_stop_any, i_free} = blk;

  always #20 i_clk = ~i_clk;

  driver_status_output_logic #(.STARTUP(8), .TICK_CYCLES(10))
    driver_status_output_logic_inst (.*);

  ctrl_model ctrl_model_inst (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_go(go),
    .i_ready(o_ready),
    .i_brake_release_ctrl(o_brake_release_ctrl),
    .o_start_any(i_start_any),
    .o_brake_engaged(brake_held)
  );

  // ----------------------------------------
  // Access and checking tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= v;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 v = o_rdata;
  endtask : rd

  // Status inputs take three edges to reach most outputs, four for the notice outputs; five leaves margin.
  task automatic settle();
    repeat (5) @(posedge i_clk);
    #1;
  endtask : settle

  task automatic test_end(input string name);
    $display("test %s done, mismatches so far %0d", name, bad_count);
  endtask : test_end

  task automatic end_of_test();
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_of_test

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    repeat (12) @(posedge i_clk);
    i_rst <= 1'b0;
    rd(ADDR_CTRL, d); check(d, 32'h7);
    rd(ADDR_INPOS, d); check(d, 32'h12);
    rd(ADDR_SPEED, d); check(d, 32'h1E);
    rd(ADDR_MOVE_MIN, d); check(d, 32'h0);
    rd(4'hF, d); check(d, 32'h0);
    for (int i = 0; i < 40 && o_system_ready_flag !== 1'b1; i++) @(posedge i_clk);
    #1 check(o_system_ready_flag, 1'b1);
    settle(); check({o_ready, o_main_supply_on}, 2'b11);
    rd(ADDR_STATUS, d); check(d, 32'h4122);
    for (int k = 0; k < 8; k++) begin
      @(posedge i_clk); blk <= 8'h01 << k;
      settle(); check(o_ready, 1'b0);
      if (k == 6) check({o_alarm_normally_open, o_alarm_normally_closed}, 2'b10);
      if (k == 6) check({o_motor_stop, o_led_green}, 2'b10);
      if (k == 5) check(o_maintenance_busy, 1'b1);
      @(posedge i_clk); blk <= 8'h00;
    end
    @(posedge i_clk); i_con_assigned <= 1'b1;
    settle(); check(o_ready, 1'b0);
    @(posedge i_clk); i_con <= 1'b1; go <= 1'b1;
    settle(); settle(); check({i_start_any, o_ready}, 2'b10);
    @(posedge i_clk); go <= 1'b0; i_main_supply <= 1'b0;
    settle(); check({o_ready, o_main_supply_on}, 2'b00);
    test_end("ready");
    @(posedge i_clk); i_excite_req <= 1'b1;
    settle(); check(o_excitation_active, 1'b1);
    @(posedge i_clk); i_alarm_deexcite <= 1'b1; blk <= 8'hC0;
    settle(); check(o_excitation_active, 1'b1);
    @(posedge i_clk); blk <= 8'h40;
    settle(); check(o_excitation_active, 1'b0);
    @(posedge i_clk); blk <= 8'h00; i_alarm_deexcite <= 1'b0; i_brake_release <= 1'b1;
    i_regen_level <= 1'b1; i_oscillating <= 1'b1; i_current_ctrl_select <= 1'b1;
    settle(); check({o_brake_release_ctrl, brake_held}, 2'b10);
    check({o_regen_active, o_oscillation_busy, o_servo_emul_mode}, 3'b011);
    @(posedge i_clk); i_regen_fitted <= 1'b1; i_current_ctrl_select <= 1'b0;
    settle(); check({o_regen_active, o_servo_emul_mode}, 2'b10);
    test_end("hardware");
    @(posedge i_clk); i_notice_cause <= 8'h05;
    settle(); check({o_notice, o_notice_flags}, 9'h105);
    @(posedge i_clk); i_notice_cause <= 8'h00;
    settle(); check({o_notice, o_notice_flags}, 9'h000);
    wr(ADDR_CTRL, 32'h6);
    @(posedge i_clk); i_notice_cause <= 8'h05;
    @(posedge i_clk); i_notice_cause <= 8'h00;
    settle(); check({o_notice, o_notice_flags}, 9'h105);
    rd(ADDR_NOTICE, d); check(d, 32'h5);
    for (int i = 0; i < 6000 && o_led_red !== 1'b1; i++) @(posedge i_clk);
    #1 check({o_led_red, o_led_green}, 2'b11);
    @(posedge i_clk); i_notice_clear_input <= 1'b1;
    settle(); check({o_notice, o_notice_flags}, 9'h000);
    check({o_led_red, o_led_green}, 2'b01);
    @(posedge i_clk); i_notice_clear_input <= 1'b0;
    test_end("notice");
    wr(ADDR_MOVE_MIN, 32'h5);
    @(posedge i_clk); blk <= 8'h80;
    repeat (2) @(posedge i_clk); blk <= 8'h00;
    repeat (30) @(posedge i_clk); #1 check(o_moving, 1'b1);
    repeat (20) @(posedge i_clk); #1 check(o_moving, 1'b1);
    repeat (60) @(posedge i_clk); #1 check(o_moving, 1'b0);
    test_end("moving");
    wr(ADDR_INPOS, 32'h0312);
    @(posedge i_clk); i_position_done <= 1'b1; i_position_error <= 16'sd21;
    settle(); check(o_in_position, 1'b1);
    @(posedge i_clk); i_position_error <= 16'sd22;
    settle(); check(o_in_position, 1'b0);
    @(posedge i_clk); i_position_error <= 16'sd21; i_interrupted <= 1'b1;
    settle(); check(o_in_position, 1'b0);
    test_end("position");
    @(posedge i_clk); i_deviation <= 16'd19;
    settle(); check(o_torque_limit_hit, 1'b1);
    @(posedge i_clk); i_deviation <= 16'd18; i_current_ctrl_select <= 1'b1;
    i_current_at_limit <= 1'b1;
    wr(ADDR_CTRL, 32'h6407);
    settle(); check(o_torque_limit_hit, 1'b1);
    wr(ADDR_CTRL, 32'h3207);
    settle(); check(o_torque_limit_hit, 1'b0);
    @(posedge i_clk); i_deviation <= 16'd19;
    settle(); check(o_torque_limit_hit, 1'b1);
    @(posedge i_clk); i_deviation <= 16'd0; i_current_at_limit <= 1'b0; i_push_limit <= 1'b1;
    settle(); check(o_torque_limit_hit, 1'b1);
    test_end("torque");
    @(posedge i_clk); i_feedback_speed <= 16'd500; i_target_speed <= 16'd100;
    i_command_speed <= 16'd100;
    settle(); check(o_speed_attained, 1'b0);
    wr(ADDR_CTRL, 32'h0F);
    settle(); check(o_speed_attained, 1'b1);
    wr(ADDR_CTRL, 32'h2F);
    settle(); check(o_speed_attained, 1'b0);
    wr(ADDR_CTRL, 32'h17);
    settle(); check(o_speed_attained, 1'b0);
    @(posedge i_clk); i_feedback_speed <= 16'd120;
    settle(); check(o_speed_attained, 1'b1);
    test_end("speed");
    @(posedge i_clk); i_cutback_reached <= 1'b1;
    settle(); check(o_current_cutback_active, 1'b1);
    wr(ADDR_CTRL, 32'h3);
    settle(); check(o_current_cutback_active, 1'b0);
    test_end("cutback");
    end_of_test();
  end

  initial begin
    repeat (20000) @(posedge i_clk);
    bad_count++;
    $display("[FAIL] %0t run did not finish", $time);
    end_of_test();
  end
endmodule : tb_top
